// *** dv/tb_tboc_top.sv ***
// Self-checking bench for the ownership controller.
// Assumes the checker is bound in and the target model sits on the pins.
`timescale 1ns/1ps
module tb_tboc_top;
  reg core_clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, op_start = 1'b0;
  reg [1:0] op_mode = 2'h0;
  reg [5:0] op_bits = 6'h00;
  reg load_valid = 1'b0, load_data = 1'b0, load_select = 1'b0;
  reg sck = 1'b0, vref_ok = 1'b1, clear = 1'b0;
  wire op_ready, op_busy, op_done_q, line_o, line_oe, d_q, d_oe, s_q, s_oe, line, spi_oe;
  wire [15:0] cap_data, cap_sel;
  wire [4:0] cap_cnt;
  wire cfg_done;
  integer fail_count = 0, tests_run = 0, cycles = 0, done_cnt = 0, n0, i, md_i;
  localparam [15:0] PAT_D = 16'ha5c3;
  localparam [15:0] PAT_S = 16'h3c5a;
  reg [31:0] m;
  always #4 core_clk = ~core_clk;
  tboc_top DUT (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en), .op_start(op_start),
    .op_mode(op_mode), .op_bits(op_bits), .load_valid(load_valid), .load_data(load_data),
    .load_select(load_select), .op_ready(op_ready), .op_busy(op_busy), .op_done_q(op_done_q),
    .shift_clock_in(sck), .vref_ok(vref_ok), .target_release_line_o(line_o),
    .target_release_line_oe(line_oe), .data_out_q(d_q), .data_out_oe_q(d_oe),
    .mode_select_out_q(s_q), .mode_select_out_oe_q(s_oe));
  tboc_target_model u_tgt (.release_oe(line_oe), .shift_clock(sck), .data_q(d_q),
    .data_oe(d_oe), .sel_q(s_q), .sel_oe(s_oe), .clear(clear), .target_release_line(line),
    .fpga_spi_oe(spi_oe), .cap_data(cap_data), .cap_sel(cap_sel), .cap_cnt(cap_cnt),
    .cfg_done(cfg_done));
  // ----
  // Checking and closing
  // ----
  task check(input [15:0] seen, input [15:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("compares %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (op_done_q === 1'b1) done_cnt <= done_cnt + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      give_verdict;
    end
  end
  task wait_ready;
    for (i = 0; i < 50 && op_ready !== 1'b1; i = i + 1) @(posedge core_clk);
    check(16'(op_ready), 16'h0001);
  endtask
  task start(input [1:0] md, input [5:0] n);
    for (i = 0; i < n; i = i + 1) begin
      load_valid <= 1'b1;
      load_data <= PAT_D[i];
      load_select <= PAT_S[i];
      @(posedge core_clk);
    end
    load_valid <= 1'b0;
    op_mode <= md;
    op_bits <= n;
    op_start <= 1'b1;
    @(posedge core_clk);
    op_start <= 1'b0;
    n0 = done_cnt;
  endtask
  // ----
  // Scenarios
  // ----
  task run_op(input [1:0] md, input [5:0] n);
    clear <= 1'b1;
    @(posedge core_clk);
    clear <= 1'b0;
    start(md, n);
    repeat (5) @(posedge core_clk);
    check(16'(line), 16'h0000);
    check(16'(spi_oe), 16'h0000);
    // Shift clock runs only inside the frame and parks low.
    for (i = 0; i < n + 1; i = i + 1) begin
      repeat (10) @(posedge core_clk);
      sck <= 1'b1;
      repeat (10) @(posedge core_clk);
      sck <= 1'b0;
    end
    wait_ready;
    // One more edge lets the done counter settle before it is read.
    @(posedge core_clk);
    m = (32'h1 << n) - 32'h1;
    check(cap_data & m[15:0], 16'ha5c3 & m[15:0]);
    check(cap_sel & m[15:0], 16'h3c5a & m[15:0]);
    check(16'(done_cnt - n0), 16'h0001);
    check(16'(line), 16'h0001);
    check(16'(d_oe), 16'h0000);
    check(16'(s_oe), 16'h0000);
    check(16'(line_o), 16'h0000);
    check(16'(cfg_done), 16'h0001);
    if (n < 6'h10) check(16'(cap_data[n[3:0]]), 16'h0001);
  endtask
  task refuse(input [1:0] md, input [5:0] n);
    op_mode <= md;
    op_bits <= n;
    op_start <= 1'b1;
    @(posedge core_clk);
    op_start <= 1'b0;
    repeat (4) @(posedge core_clk);
    check(16'(op_busy), 16'h0000);
    check(16'(line_oe), 16'h0000);
  endtask
  task frozen;
    clk_en <= 1'b0;
    op_mode <= 2'h2;
    op_bits <= 6'h04;
    op_start <= 1'b1;
    repeat (4) @(posedge core_clk);
    op_start <= 1'b0;
    clk_en <= 1'b1;
    repeat (2) @(posedge core_clk);
    check(16'(op_busy), 16'h0000);
    check(16'(line_oe), 16'h0000);
  endtask
  task vref_drop;
    start(2'h2, 6'h04);
    repeat (6) @(posedge core_clk);
    vref_ok <= 1'b0;
    for (i = 0; i < 40 && done_cnt == n0; i = i + 1) @(posedge core_clk);
    check(16'(d_oe), 16'h0000);
    check(16'(done_cnt - n0), 16'h0001);
    vref_ok <= 1'b1;
    wait_ready;
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    wait_ready;
    for (md_i = 0; md_i < 3; md_i = md_i + 1) begin
      run_op(md_i[1:0], 6'h01);
      run_op(md_i[1:0], 6'h10);
    end
    frozen;
    refuse(2'h3, 6'h04);
    refuse(2'h0, 6'h00);
    refuse(2'h1, 6'h11);
    vref_drop;
    give_verdict;
  end
endmodule

// *** dv/tboc_checker.sv ***
// Port checker for the ownership controller.
// Assumes it is bound to tboc_top and sees only its ports.
`timescale 1ns/1ps
module tboc_checker (
  // Clock, reset and requests
  input wire core_clk,
  input wire resetn,
  input wire clk_en,
  input wire op_start,
  input wire [1:0] op_mode,
  input wire [5:0] op_bits,
  input wire op_ready,
  input wire op_done_q,
  // Sensing
  input wire shift_clock_in,
  input wire vref_ok,
  // Target pins
  input wire target_release_line_o,
  input wire target_release_line_oe,
  input wire data_out_q,
  input wire data_out_oe_q,
  input wire mode_select_out_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  AST_NEVER_HIGH: assert property (target_release_line_o == 1'b0)
    else $error("release line driven high");
  AST_START_CLAIMS: assert property (op_start && op_ready && clk_en && op_mode != 2'h3 &&
    op_bits != 6'h00 && op_bits <= 6'h10 |=> target_release_line_oe) else $error("no claim");
  AST_IDLE_FREE: assert property (op_ready |-> !target_release_line_oe)
    else $error("line held while idle");
  AST_DRV_INSIDE: assert property (data_out_oe_q |-> target_release_line_oe)
    else $error("drivers on without line");
  AST_CLAIM_FIRST: assert property ($rose(data_out_oe_q) |-> $past(target_release_line_oe, 3))
    else $error("drivers before claim gap");
  AST_FREE_LAST: assert property ($fell(target_release_line_oe) |-> !$past(data_out_oe_q, 2))
    else $error("line freed too early");
  AST_DONE_FREES: assert property (op_done_q |-> $fell(target_release_line_oe))
    else $error("done without release");
  AST_HIGH_BEFORE_Z: assert property ($fell(data_out_oe_q) && vref_ok && $past(vref_ok, 6)
    |-> $past(data_out_q && mode_select_out_q)) else $error("released while low");
  AST_VREF_CUTS: assert property (!vref_ok [*6] |-> !data_out_oe_q)
    else $error("drivers on with low reference");
  AST_CHANGE_ON_FALL: assert property (data_out_oe_q && $past(data_out_oe_q) &&
    ($changed(data_out_q) || $changed(mode_select_out_q)) |-> !shift_clock_in)
    else $error("outputs changed outside falling edge");
endmodule

bind tboc_top tboc_checker u_chk (.core_clk, .resetn, .clk_en, .op_start, .op_mode, .op_bits,
  .op_ready, .op_done_q, .shift_clock_in, .vref_ok, .target_release_line_o,
  .target_release_line_oe, .data_out_q, .data_out_oe_q, .mode_select_out_q);

// *** dv/tboc_target_model.sv ***
// Target board model: pulled-up release line, chain mux, one flash, two FPGAs.
// Assumes the bench supplies the shift clock and a capture clear.
`timescale 1ns/1ps
module tboc_target_model (
  // Pod side
  input wire release_oe,
  input wire shift_clock,
  input wire data_q,
  input wire data_oe,
  input wire sel_q,
  input wire sel_oe,
  input wire clear,
  // Board view
  output wire target_release_line,
  output wire fpga_spi_oe,
  output reg [15:0] cap_data,
  output reg [15:0] cap_sel,
  output reg [4:0] cap_cnt,
  output wire cfg_done
);
  // Board pull-up: the line reads high whenever the pod lets go.
  assign target_release_line = release_oe ? 1'b0 : 1'b1;
  // The FPGA program input follows the line; held low, its SPI pins float.
  assign fpga_spi_oe = target_release_line;
  // Pod pins fall back to their weak pull-ups when not driven.
  wire d_pin = data_oe ? data_q : 1'b1;
  wire s_pin = sel_oe ? sel_q : 1'b1;
  // Two cascaded FPGAs pull the shared completion line low until they are loaded.
  // With open-drain outputs the single pull-up wins only once both let go.
  wire [1:0] done_pull_low = {2{cap_cnt == 5'h00}};
  assign cfg_done = ~|done_pull_low;
  // The single flash samples on rising edges, only while routed to the pod.
  always @(posedge shift_clock or posedge clear) begin
    if (clear) begin
      cap_cnt <= 5'h00;
      cap_data <= 16'h0000;
      cap_sel <= 16'h0000;
    end else if (!target_release_line && cap_cnt < 5'h10) begin
      cap_data[cap_cnt[3:0]] <= d_pin;
      cap_sel[cap_cnt[3:0]] <= s_pin;
      cap_cnt <= cap_cnt + 5'h01;
    end
  end
endmodule

// *** logic/tboc_mem.v ***
// Small synchronous memory holding shift bits (data and mode/select pairs).
// Assumes a single clock; read data comes out of a register.
`timescale 1ns/1ps
`include "tboc_defines.vh"

module tboc_mem (
  // Clock
  input wire clk,
  input wire ce,
  // Write side
  input wire wr_en,
  input wire [`TBOC_AW-1:0] wr_addr,
  input wire [1:0] wr_data,
  // Read side
  input wire [`TBOC_AW-1:0] rd_addr,
  output reg [1:0] rd_data_q
);

  reg [1:0] mem [0:`TBOC_DEPTH-1];

  always @(posedge clk) begin
    if (ce) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data_q <= mem[rd_addr];
    end
  end

endmodule

// *** logic/tboc_top.v ***
// Target bus ownership controller: claims the target configuration chain
// through an open-drain release line and drives data and mode/select.
// Assumes an external shift clock arriving from the pod's clock generator
// and a sensed comparator flag for the target reference voltage.
`timescale 1ns/1ps
`include "tboc_defines.vh"

module tboc_top (
  // Clock and reset
  input wire core_clk,
  input wire resetn,
  input wire clk_en,
  // Operation request
  input wire op_start,
  input wire [1:0] op_mode,
  input wire [`TBOC_BITS_W-1:0] op_bits,
  input wire load_valid,
  input wire load_data,
  input wire load_select,
  output wire op_ready,
  output wire op_busy,
  output reg op_done_q,
  // Sensing from outside the clock domain
  input wire shift_clock_in,
  input wire vref_ok,
  // Target release line, open-drain
  output wire target_release_line_o,
  output wire target_release_line_oe,
  // Target data and mode/select pins
  output reg data_out_q,
  output reg data_out_oe_q,
  output reg mode_select_out_q,
  output reg mode_select_out_oe_q
);

  // ----------------------------------------------------------------
  // Reset release and input synchronisers
  // ----------------------------------------------------------------
  reg [1:0] rst_sync_q;
  wire rst_n = rst_sync_q[1];

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  reg sck_meta_q, sck_sync_q, sck_prev_q;
  reg vref_meta_q, vref_sync_q;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_meta_q <= 1'b0;
      sck_sync_q <= 1'b0;
      sck_prev_q <= 1'b0;
      vref_meta_q <= 1'b0;
      vref_sync_q <= 1'b0;
    end else if (clk_en) begin
      sck_meta_q <= shift_clock_in;
      sck_sync_q <= sck_meta_q;
      sck_prev_q <= sck_sync_q;
      vref_meta_q <= vref_ok;
      vref_sync_q <= vref_meta_q;
    end
  end

  wire sck_fall = sck_prev_q & ~sck_sync_q;

  // ----------------------------------------------------------------
  // Constants and helpers
  // ----------------------------------------------------------------
  localparam integer GAP_CYC_I = (`TBOC_GAP_NS + `TBOC_CLK_NS - 1) / `TBOC_CLK_NS;
  localparam [`TBOC_GAP_W-1:0] GAP_CYC = GAP_CYC_I[`TBOC_GAP_W-1:0];

  localparam [4:0] ST_IDLE = `TBOC_ST_IDLE;
  localparam [4:0] ST_CLAIM = `TBOC_ST_CLAIM;
  localparam [4:0] ST_DRIVE = `TBOC_ST_DRIVE;
  localparam [4:0] ST_PARK = `TBOC_ST_PARK;
  localparam [4:0] ST_FREE = `TBOC_ST_FREE;

  function [`TBOC_AW-1:0] addr_inc;
    input [`TBOC_AW-1:0] a;
    begin
      addr_inc = a + `TBOC_AW_ONE;
    end
  endfunction

  function mode_known;
    input [1:0] m;
    begin
      mode_known = (m == `TBOC_MODE_JTAG) || (m == `TBOC_MODE_SSER) ||
                   (m == `TBOC_MODE_SPI);
    end
  endfunction

  // ----------------------------------------------------------------
  // Bit store
  // ----------------------------------------------------------------
  reg [4:0] state_q, state_d;
  reg [`TBOC_AW-1:0] wr_ptr_q, rd_ptr_q;
  reg [`TBOC_BITS_W-1:0] left_q;
  reg [`TBOC_GAP_W-1:0] gap_q;
  reg [1:0] mode_q;
  reg claim_q;
  wire [1:0] rd_bits;

  // One request may be accepted while idle; bits are loaded before it, also while idle.
  wire idle = (state_q == ST_IDLE);
  wire start_ok = idle & op_start & vref_sync_q & mode_known(op_mode) &
                  (op_bits != `TBOC_BITS_ZERO) & (op_bits <= `TBOC_DEPTH);
  assign op_ready = idle & vref_sync_q;
  assign op_busy = ~idle;

  wire wr_en = clk_en & load_valid & idle;

  tboc_mem u_mem (
    .clk(core_clk),
    .ce(clk_en),
    .wr_en(wr_en),
    .wr_addr(wr_ptr_q),
    .wr_data({load_select, load_data}),
    .rd_addr(rd_ptr_q),
    .rd_data_q(rd_bits)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start_ok) begin
          state_d = ST_CLAIM;
        end
      end
      ST_CLAIM: begin
        if (!vref_sync_q) begin
          state_d = ST_FREE;
        end else if (gap_q == GAP_CYC) begin
          state_d = ST_DRIVE;
        end
      end
      ST_DRIVE: begin
        if (!vref_sync_q) begin
          state_d = ST_FREE;
        end else if (sck_fall && left_q == `TBOC_BITS_ZERO) begin
          state_d = ST_PARK;
        end
      end
      ST_PARK: begin
        if (!vref_sync_q || sck_fall) begin
          state_d = ST_FREE;
        end
      end
      ST_FREE: begin
        if (gap_q == GAP_CYC) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      wr_ptr_q <= {`TBOC_AW{1'b0}};
      rd_ptr_q <= {`TBOC_AW{1'b0}};
      left_q <= `TBOC_BITS_ZERO;
      gap_q <= {`TBOC_GAP_W{1'b0}};
      mode_q <= `TBOC_MODE_JTAG;
      claim_q <= 1'b0;
      op_done_q <= 1'b0;
      data_out_q <= 1'b1;
      data_out_oe_q <= 1'b0;
      mode_select_out_q <= 1'b1;
      mode_select_out_oe_q <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      op_done_q <= 1'b0;
      if (state_d != state_q) begin
        gap_q <= {`TBOC_GAP_W{1'b0}};
      end else if (gap_q != GAP_CYC) begin
        gap_q <= gap_q + 1'b1;
      end
      if (wr_en) begin
        wr_ptr_q <= addr_inc(wr_ptr_q);
      end
      case (state_q)
        ST_IDLE: begin
          if (start_ok) begin
            mode_q <= op_mode;
            left_q <= op_bits - `TBOC_BITS_ONE;
            rd_ptr_q <= {`TBOC_AW{1'b0}};
            // Line low before any driver turns on, in every mode.
            claim_q <= 1'b1;
          end
        end
        ST_CLAIM: begin
          if (state_d == ST_DRIVE) begin
            // Drivers on with the first bit; release line already low.
            data_out_q <= rd_bits[0];
            mode_select_out_q <= rd_bits[1];
            data_out_oe_q <= 1'b1;
            mode_select_out_oe_q <= 1'b1;
            rd_ptr_q <= addr_inc(rd_ptr_q);
          end
        end
        ST_DRIVE: begin
          if (sck_fall && state_d == ST_DRIVE) begin
            data_out_q <= rd_bits[0];
            mode_select_out_q <= rd_bits[1];
            rd_ptr_q <= addr_inc(rd_ptr_q);
            left_q <= left_q - `TBOC_BITS_ONE;
          end else if (state_d == ST_PARK) begin
            // Drive high before letting the pull-ups take over.
            data_out_q <= 1'b1;
            mode_select_out_q <= 1'b1;
          end
        end
        ST_PARK: begin
          if (state_d == ST_FREE) begin
            data_out_oe_q <= 1'b0;
            mode_select_out_oe_q <= 1'b0;
          end
        end
        ST_FREE: begin
          // Low reference voltage forces drivers off one cycle after the move to this state.
          data_out_oe_q <= 1'b0;
          mode_select_out_oe_q <= 1'b0;
          data_out_q <= 1'b1;
          mode_select_out_q <= 1'b1;
          if (state_d == ST_IDLE) begin
            // Line released only after drivers are off.
            claim_q <= 1'b0;
            op_done_q <= 1'b1;
            wr_ptr_q <= {`TBOC_AW{1'b0}};
          end
        end
        default: begin
          claim_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Release line
  // ----------------------------------------------------------------
  // Open drain: the output value is always low, only the enable moves.
  assign target_release_line_o = 1'b0;
  assign target_release_line_oe = claim_q;

endmodule

// *** pkg/tboc_defines.vh ***
// Constants for the target bus ownership controller.
// Assumes inclusion by bare name from the design files.
`ifndef TBOC_DEFINES_VH
`define TBOC_DEFINES_VH

// Operating modes.
`define TBOC_MODE_JTAG 2'h0
`define TBOC_MODE_SSER 2'h1
`define TBOC_MODE_SPI 2'h2

// Sequencer states (one-hot).
`define TBOC_ST_IDLE 5'h01
`define TBOC_ST_CLAIM 5'h02
`define TBOC_ST_DRIVE 5'h04
`define TBOC_ST_PARK 5'h08
`define TBOC_ST_FREE 5'h10

// Settle gap between release line and driver changes.
`define TBOC_GAP_NS 16
`define TBOC_CLK_NS 8
`define TBOC_GAP_W 4

// Frame buffer geometry and reset values.
`define TBOC_DEPTH 16
`define TBOC_AW 4
`define TBOC_AW_ONE 4'h1
`define TBOC_BITS_W 6
`define TBOC_BITS_ZERO 6'h00
`define TBOC_BITS_ONE 6'h01

`endif
